// *** core/sac_pkg.sv ***
// Constants and types shared by the sampling converter output control
package sac_pkg;

   // ----------------------------------------------------------------
   // Data path shape
   // ----------------------------------------------------------------
   localparam int SAMPLE_W = 12;
   localparam int LATENCY = 5;
   localparam int PIPE_STAGES = LATENCY;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the Avalon-MM slave)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_STATUS = 5'h04;
   localparam logic [4:0] OFS_LAST_SAMPLE = 5'h08;
   localparam logic [4:0] OFS_IRQ_STATUS = 5'h0C;
   localparam logic [4:0] OFS_IRQ_ENABLE = 5'h10;
   localparam logic [4:0] OFS_IRQ_CLEAR = 5'h14;

   // CTRL fields
   localparam int CTRL_SNAP_EN_BIT = 0;
   localparam logic CTRL_RESET = 1'b1;

   // STATUS fields
   localparam int ST_MODE_LSB = 0;
   localparam int ST_TWOS_BIT = 4;
   localparam int ST_STAB_BIT = 5;

   // LAST_SAMPLE fields
   localparam int LS_FLAG_BIT = 12;

   // Interrupt event bits
   localparam int IRQ_W = 3;
   localparam int EV_SAMPLE = 0;
   localparam int EV_RANGE = 1;
   localparam int EV_MODE = 2;
   localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 3'h0;

   // ----------------------------------------------------------------
   // Format strap levels, as quantised by the pin comparators
   // ----------------------------------------------------------------
   localparam logic [1:0] FMT_GND = 2'h0;
   localparam logic [1:0] FMT_THIRD = 2'h1;
   localparam logic [1:0] FMT_TWO_THIRDS = 2'h2;
   localparam logic [1:0] FMT_FULL = 2'h3;

   // ----------------------------------------------------------------
   // Operating modes, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      SAC_RUN_DRIVE = 4'h1,
      SAC_RUN_HIZ = 4'h2,
      SAC_NAP = 4'h4,
      SAC_SLEEP = 4'h8
   } sac_mode_t;

endpackage

// *** core/sac_output_ctrl.sv ***
// Output control of a pipelined 12-bit sampling converter with Avalon-MM status access
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module sac_output_ctrl (
   // System clock and reset
   input wire logic i_mclk,
   input wire logic i_srst,
   // Device pins (asynchronous to i_mclk)
   input wire logic i_sample_clk,
   input wire logic i_power_down_select,
   input wire logic i_output_enable_n,
   input wire logic [1:0] i_format_level,
   // Quantiser result from the conversion core (i_mclk domain)
   input wire logic [sac_pkg::SAMPLE_W-1:0] i_core_code,
   input wire logic i_core_out_of_range,
   // Parallel outputs, enables low while driving
   output logic [sac_pkg::SAMPLE_W-1:0] o_sample_code_bits,
   output logic [sac_pkg::SAMPLE_W-1:0] o_sample_code_bits_oe_n,
   output logic o_range_exceeded_flag,
   output logic o_range_exceeded_flag_oe_n,
   // Clock conditioning control
   output logic o_stabilizer_on,
   // Avalon-MM slave
   input wire logic [sac_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Interrupt
   output logic o_irq
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic sclk_sync;
   logic sclk_prev_q;
   logic sample_edge;
   logic pd_sel;
   logic oe_n;
   logic [1:0] fmt_lvl;

   // Each pin gets its own two-flop chain; only the second stage reaches logic
   sac_sync2 #(
      .W(1)
   ) sclk_sync_u (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_d(i_sample_clk),
      .o_q(sclk_sync)
   );

   sac_sync2 #(
      .W(1)
   ) pd_sync_u (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_d(i_power_down_select),
      .o_q(pd_sel)
   );

   sac_sync2 #(
      .W(1)
   ) oe_sync_u (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_d(i_output_enable_n),
      .o_q(oe_n)
   );

   // The two strap bits may settle a cycle apart; the strap is meant to stay static
   sac_sync2 #(
      .W(2)
   ) fmt_sync_u (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_d(i_format_level),
      .o_q(fmt_lvl)
   );

   // Rising edge detector on the synchronised sample clock
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_sync;
      end
   end

   assign sample_edge = sclk_sync & ~sclk_prev_q;

   // ----------------------------------------------------------------
   // Operating mode
   // ----------------------------------------------------------------
   sac_pkg::sac_mode_t mode_q;
   sac_pkg::sac_mode_t mode_d;
   logic converting;
   logic drive;

   // Mode follows the two pins every cycle
   always_comb begin
      unique case ({pd_sel, oe_n})
         2'b00: mode_d = sac_pkg::SAC_RUN_DRIVE;
         2'b01: mode_d = sac_pkg::SAC_RUN_HIZ;
         2'b10: mode_d = sac_pkg::SAC_NAP;
         2'b11: mode_d = sac_pkg::SAC_SLEEP;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         mode_q <= sac_pkg::SAC_SLEEP;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Nap and sleep freeze the pipeline; high-impedance run keeps it moving
   assign converting = (mode_q == sac_pkg::SAC_RUN_DRIVE) || (mode_q == sac_pkg::SAC_RUN_HIZ);
   assign drive = (mode_q == sac_pkg::SAC_RUN_DRIVE);

   // ----------------------------------------------------------------
   // Format strap decode
   // ----------------------------------------------------------------
   logic twos_q;
   logic stab_q;

   // Registered so the coding never changes mid-cycle of the output stage
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         twos_q <= 1'b0;
      end else begin
         twos_q <= (fmt_lvl == sac_pkg::FMT_TWO_THIRDS) || (fmt_lvl == sac_pkg::FMT_FULL);
      end
   end

   // Stabilizer setting only; the clock shaping itself lies outside this block
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         stab_q <= 1'b0;
      end else begin
         stab_q <= (fmt_lvl == sac_pkg::FMT_THIRD) || (fmt_lvl == sac_pkg::FMT_TWO_THIRDS);
      end
   end

   assign o_stabilizer_on = stab_q;

   // ----------------------------------------------------------------
   // Conversion pipeline
   // ----------------------------------------------------------------
   logic [sac_pkg::SAMPLE_W:0] pipe_q [sac_pkg::PIPE_STAGES];
   logic [sac_pkg::SAMPLE_W-1:0] code_q;
   logic flag_q;
   logic sample_done;

   assign sample_done = sample_edge & converting;

   // Flag and word share one stage entry so they cannot drift apart
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         for (int i = 0; i < sac_pkg::PIPE_STAGES; i++) begin
            pipe_q[i] <= 13'h0000;
         end
      end else if (sample_done) begin
         pipe_q[0] <= {i_core_out_of_range, i_core_code};
         for (int i = 1; i < sac_pkg::PIPE_STAGES; i++) begin
            pipe_q[i] <= pipe_q[i-1];
         end
      end
   end

   // Output stage is the sixth edge; two's complement inverts the MSB
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         code_q <= 12'h000;
      end else if (sample_done) begin
         code_q <= pipe_q[sac_pkg::PIPE_STAGES-1][sac_pkg::SAMPLE_W-1:0] ^
                   {twos_q, {(sac_pkg::SAMPLE_W-1){1'b0}}};
      end
   end

   // The flag leaves the same stage entry as its word, in the same cycle
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         flag_q <= 1'b0;
      end else if (sample_done) begin
         flag_q <= pipe_q[sac_pkg::PIPE_STAGES-1][sac_pkg::SAMPLE_W];
      end
   end

   // Pads float outside the driving mode
   assign o_sample_code_bits = code_q;
   assign o_range_exceeded_flag = flag_q;
   assign o_sample_code_bits_oe_n = {sac_pkg::SAMPLE_W{~drive}};
   assign o_range_exceeded_flag_oe_n = ~drive;

   // ----------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------
   logic ack_q;
   logic req;
   logic wr_take;
   logic [31:0] rdata_q;
   logic snap_en_q;
   logic [sac_pkg::SAMPLE_W:0] last_q;
   logic [sac_pkg::IRQ_W-1:0] irq_stat_q;
   logic [sac_pkg::IRQ_W-1:0] irq_en_q;
   logic [sac_pkg::IRQ_W-1:0] events;
   logic [sac_pkg::IRQ_W-1:0] clr;
   logic [31:0] rd_mux;

   // Fixed one wait state: answer at the second edge of every request
   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack_q;
   assign wr_take = i_avs_write & ack_q;

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // Read multiplexer; unmapped offsets read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (i_avs_address)
         sac_pkg::OFS_CTRL: rd_mux[sac_pkg::CTRL_SNAP_EN_BIT] = snap_en_q;
         sac_pkg::OFS_STATUS: begin
            rd_mux[sac_pkg::ST_MODE_LSB +: 4] = mode_q;
            rd_mux[sac_pkg::ST_TWOS_BIT] = twos_q;
            rd_mux[sac_pkg::ST_STAB_BIT] = stab_q;
         end
         sac_pkg::OFS_LAST_SAMPLE: rd_mux[sac_pkg::LS_FLAG_BIT:0] = last_q;
         sac_pkg::OFS_IRQ_STATUS: rd_mux[sac_pkg::IRQ_W-1:0] = irq_stat_q;
         sac_pkg::OFS_IRQ_ENABLE: rd_mux[sac_pkg::IRQ_W-1:0] = irq_en_q;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is captured in the wait cycle and stands at the answer edge
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rdata_q <= 32'h0000_0000;
      end else if (i_avs_read & ~ack_q) begin
         rdata_q <= rd_mux;
      end
   end

   assign o_avs_readdata = rdata_q;

   // Snapshot enable; a write takes effect at its answer edge
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         snap_en_q <= sac_pkg::CTRL_RESET;
      end else if (wr_take && i_avs_address == sac_pkg::OFS_CTRL) begin
         snap_en_q <= i_avs_writedata[sac_pkg::CTRL_SNAP_EN_BIT];
      end
   end

   // Interrupt mask; writing it never touches the sticky status itself
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         irq_en_q <= sac_pkg::IRQ_EN_RESET;
      end else if (wr_take && i_avs_address == sac_pkg::OFS_IRQ_ENABLE) begin
         irq_en_q <= i_avs_writedata[sac_pkg::IRQ_W-1:0];
      end
   end

   // Snapshot of the word leaving the pipeline; software may freeze it
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         last_q <= 13'h0000;
      end else if (sample_done & snap_en_q) begin
         last_q <= {pipe_q[sac_pkg::PIPE_STAGES-1][sac_pkg::SAMPLE_W],
                    pipe_q[sac_pkg::PIPE_STAGES-1][sac_pkg::SAMPLE_W-1:0] ^
                    {twos_q, {(sac_pkg::SAMPLE_W-1){1'b0}}}};
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   assign events[sac_pkg::EV_SAMPLE] = sample_done;
   assign events[sac_pkg::EV_RANGE] = sample_done & pipe_q[sac_pkg::PIPE_STAGES-1][sac_pkg::SAMPLE_W];
   assign events[sac_pkg::EV_MODE] = (mode_d != mode_q);
   assign clr = (wr_take && i_avs_address == sac_pkg::OFS_IRQ_CLEAR) ?
                i_avs_writedata[sac_pkg::IRQ_W-1:0] : 3'h0;

   // A new event in the clearing cycle wins over the clear
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         irq_stat_q <= 3'h0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~clr) | events;
      end
   end

   assign o_irq = |(irq_stat_q & irq_en_q);

endmodule

// Two-flop synchroniser for a level that arrives from outside the clock domain
module sac_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_srst,
   // Level in and synchronised level out
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // Only the second stage leaves the module; the first may still be settling
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= i_d;
         sync_q <= meta_q;
      end
   end

   assign o_q = sync_q;

endmodule

// *** sim/sac_output_ctrl_assertions.sv ***
// Port checks for the converter output control
`timescale 1ns/1ns
module sac_chk (
   // Clock, reset and pins
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_sample_clk,
   input wire logic i_power_down_select,
   input wire logic i_output_enable_n,
   input wire logic [1:0] i_format_level,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   // Outputs
   input wire logic [sac_pkg::SAMPLE_W-1:0] o_sample_code_bits_oe_n,
   input wire logic o_range_exceeded_flag,
   input wire logic o_range_exceeded_flag_oe_n,
   input wire logic o_stabilizer_on,
   input wire logic o_avs_waitrequest
);
   // ------------------------------------------------------------
   // Helpers and checks
   // ------------------------------------------------------------
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   logic [2:0] cnt_q;
   logic [1:0] fmt_q;
   // Pins pass two synchroniser stages and the mode register, so judge them only once steady
   always_ff @(posedge i_mclk) begin
      fmt_q <= i_format_level;
      cnt_q <= i_srst ? 3'h0 : cnt_q + {2'h0, cnt_q != 3'h7};
   end
   sequence s_held(b);
      cnt_q > 3'h3 && b && $past(b) && $past(b, 2) && $past(b, 3);
   endsequence
   a_oe_pair: assert property (o_sample_code_bits_oe_n == {12{o_range_exceeded_flag_oe_n}})
      else $error("word and flag enables differ");
   a_drive_run: assert property (s_held(!i_power_down_select && !i_output_enable_n) |->
      o_sample_code_bits_oe_n == '0) else $error("outputs not driven in run mode");
   a_hiz_enable: assert property (s_held(i_output_enable_n) |-> &o_sample_code_bits_oe_n)
      else $error("outputs driven with enable pin high");
   a_hiz_powerdown: assert property (s_held(i_power_down_select) |->
      &o_sample_code_bits_oe_n) else $error("outputs driven in nap or sleep");
   a_stab_strap: assert property (s_held(i_format_level == fmt_q) |->
      o_stabilizer_on == (i_format_level[0] ^ i_format_level[1])) else $error("stabilizer wrong");
   a_flag_timing: assert property ($changed(o_range_exceeded_flag) |->
      $past(i_sample_clk, 3) && !$past(i_sample_clk, 4)) else $error("flag moved off sample edge");
   a_wait_one: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest |=>
      !o_avs_waitrequest) else $error("more than one wait state");
   a_wait_idle: assert property (!(i_avs_read | i_avs_write) |-> !o_avs_waitrequest)
      else $error("waitrequest without request");
   c_hiz: cover property (s_held(i_output_enable_n));
   c_nap: cover property (s_held(i_power_down_select));
   c_flag: cover property ($rose(o_range_exceeded_flag));
endmodule
bind sac_output_ctrl sac_chk chk_u (.i_mclk, .i_srst, .i_sample_clk, .i_power_down_select,
   .i_output_enable_n, .i_format_level, .i_avs_read, .i_avs_write, .o_sample_code_bits_oe_n,
   .o_range_exceeded_flag, .o_range_exceeded_flag_oe_n, .o_stabilizer_on, .o_avs_waitrequest);

// *** sim/sac_capture_model.sv ***
// Capture logic latching the converter's parallel word
`timescale 1ns/1ns
module sac_capture_model (
   // Clock and strobe
   input wire logic i_mclk,
   input wire logic i_sample_clk,
   // Converter pins
   input wire logic [sac_pkg::SAMPLE_W-1:0] i_code,
   input wire logic [sac_pkg::SAMPLE_W-1:0] i_code_oe_n,
   input wire logic i_flag,
   input wire logic i_flag_oe_n,
   // Latched result
   output logic [sac_pkg::SAMPLE_W-1:0] o_word,
   output logic o_flag
);
   logic [sac_pkg::SAMPLE_W-1:0] bus_q;
   logic flag_q;
   logic clk_q;
   // Released lines have no pulls, so they show the inverse of their last level
   always_ff @(posedge i_mclk) begin
      clk_q <= i_sample_clk;
      bus_q <= (i_code & ~i_code_oe_n) | (~bus_q & i_code_oe_n);
      flag_q <= i_flag_oe_n ? ~flag_q : i_flag;
      // Latch on the falling strobe, well clear of the output update
      if (clk_q && !i_sample_clk) begin
         o_word <= bus_q;
         o_flag <= flag_q;
      end
   end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the converter output control
`timescale 1ns/1ns
module tb_top;
   logic i_mclk = 1'b0;
   logic i_srst = 1'b1;
   logic i_sample_clk = 1'b0;
   logic i_power_down_select = 1'b0;
   logic i_output_enable_n = 1'b0;
   logic [1:0] i_format_level = 2'h0;
   logic [11:0] i_core_code = 12'h000;
   logic i_core_out_of_range = 1'b0;
   logic [4:0] i_avs_address = 5'h00;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0000_0000;
   logic [11:0] o_sample_code_bits, o_sample_code_bits_oe_n, cap_word;
   logic o_range_exceeded_flag, o_range_exceeded_flag_oe_n, o_stabilizer_on, o_irq, cap_flag;
   logic [31:0] o_avs_readdata, q;
   logic o_avs_waitrequest;
   logic [12:0] sent[$];
   int err_count = 0;
   int n_compared = 0;
   sac_output_ctrl dut_u (.i_mclk, .i_srst, .i_sample_clk, .i_power_down_select,
      .i_output_enable_n, .i_format_level, .i_core_code, .i_core_out_of_range,
      .o_sample_code_bits, .o_sample_code_bits_oe_n, .o_range_exceeded_flag,
      .o_range_exceeded_flag_oe_n, .o_stabilizer_on, .i_avs_address, .i_avs_read,
      .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_irq);
   sac_capture_model cap_u (.i_mclk, .i_sample_clk, .i_code(o_sample_code_bits),
      .i_code_oe_n(o_sample_code_bits_oe_n), .i_flag(o_range_exceeded_flag),
      .i_flag_oe_n(o_range_exceeded_flag_oe_n), .o_word(cap_word), .o_flag(cap_flag));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_avs_read <= !w;
      i_avs_write <= w;
      i_avs_address <= a;
      i_avs_writedata <= d;
      do @(posedge i_mclk); while (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask
   // One sample strobe; the pipeline moves only outside nap and sleep
   task automatic run_chk(input logic [11:0] c, input logic f);
      logic [12:0] e;
      @(posedge i_mclk);
      i_core_code <= c;
      i_core_out_of_range <= f;
      i_sample_clk <= 1'b1;
      repeat (4) @(posedge i_mclk);
      i_sample_clk <= 1'b0;
      repeat (5) @(posedge i_mclk);
      if (!i_power_down_select) sent.push_back({f, c});
      if (!i_power_down_select && !i_output_enable_n && sent.size() > 5) begin
         e = sent[sent.size() - 6] ^ {1'b0, i_format_level[1], 11'h000};
         check("word", o_sample_code_bits, e[11:0]);
         check("flag", o_range_exceeded_flag, e[12]);
         check("captured", {cap_flag, cap_word}, e);
         bus(1'b0, sac_pkg::OFS_LAST_SAMPLE, 32'h0000_0000);
         check("last sample", q, e);
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      bus(1'b0, sac_pkg::OFS_CTRL, 0);
      check("ctrl reset", q, sac_pkg::CTRL_RESET);
      bus(1'b0, sac_pkg::OFS_IRQ_ENABLE, 0);
      check("irq enable reset", q, sac_pkg::IRQ_EN_RESET);
      bus(1'b0, 5'h1C, 0);
      check("unmapped", q, 0);
      bus(1'b0, sac_pkg::OFS_IRQ_CLEAR, 0);
      check("clear reads zero", q, 0);
   endtask
   task automatic t_stream();
      for (int i = 0; i < 9; i++) run_chk({i[3:0], 8'hA5} ^ 12'h801, i[0] ^ i[2]);
   endtask
   // Every pin pair: mode, enables, and whether the pipeline moved
   task automatic t_modes();
      for (int m = 3; m >= 0; m--) begin
         i_power_down_select <= m[1];
         i_output_enable_n <= m[0];
         repeat (5) @(posedge i_mclk);
         bus(1'b0, sac_pkg::OFS_STATUS, 0);
         check("mode", q[3:0], 4'h1 << m);
         check("enables", o_sample_code_bits_oe_n, {12{m != 0}});
         run_chk(12'h3C0 + 12'(m), m[0]);
      end
      run_chk(12'hFFF, 1'b1);
   endtask
   task automatic t_strap();
      for (int l = 0; l < 4; l++) begin
         i_format_level <= 2'(l);
         repeat (5) @(posedge i_mclk);
         bus(1'b0, sac_pkg::OFS_STATUS, 0);
         check("strap status", q[5:4], {l[0] ^ l[1], l[1]});
         check("stabilizer", o_stabilizer_on, l[0] ^ l[1]);
         run_chk(12'h7F0 | 12'(l), 1'b0);
      end
   endtask
   // Frozen snapshot survives new samples; an enable pin change raises the mode event
   task automatic t_snap();
      logic [31:0] held;
      bus(1'b0, sac_pkg::OFS_LAST_SAMPLE, 0);
      held = q;
      bus(1'b1, sac_pkg::OFS_CTRL, 32'h0000_0000);
      bus(1'b0, sac_pkg::OFS_CTRL, 0);
      check("ctrl written", q, 0);
      bus(1'b1, sac_pkg::OFS_IRQ_CLEAR, 32'h0000_0007);
      i_output_enable_n <= 1'b1;
      run_chk(12'h9AB, 1'b1);
      bus(1'b0, sac_pkg::OFS_LAST_SAMPLE, 0);
      check("snapshot frozen", q, held);
      bus(1'b0, sac_pkg::OFS_IRQ_STATUS, 0);
      check("mode event", q[sac_pkg::EV_MODE], 1'b1);
      check("hiz flag enable", o_range_exceeded_flag_oe_n, 1'b1);
      i_output_enable_n <= 1'b0;
      bus(1'b1, sac_pkg::OFS_CTRL, 32'h0000_0001);
   endtask
   // Sticky sample event raises, clears and is masked
   task automatic t_irq();
      bus(1'b1, sac_pkg::OFS_IRQ_CLEAR, 32'h0000_0007);
      bus(1'b1, sac_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
      @(posedge i_mclk);
      check("irq idle", o_irq, 1'b0);
      run_chk(12'h123, 1'b0);
      check("irq raised", o_irq, 1'b1);
      bus(1'b1, sac_pkg::OFS_IRQ_CLEAR, 32'h0000_0001);
      @(posedge i_mclk);
      check("irq cleared", o_irq, 1'b0);
      bus(1'b1, sac_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
      run_chk(12'h456, 1'b1);
      check("irq masked", o_irq, 1'b0);
      bus(1'b0, sac_pkg::OFS_IRQ_STATUS, 0);
      check("sticky", q[0], 1'b1);
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial forever #4 i_mclk = ~i_mclk;
   initial begin
      repeat (20000) @(posedge i_mclk);
      err_count++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge i_mclk);
      i_srst <= 1'b0;
      repeat (4) @(posedge i_mclk);
      t_regs();
      t_stream();
      t_modes();
      t_strap();
      t_snap();
      t_irq();
      final_report();
   end
endmodule
